// File: shared/skc_defines.svh
/*
 * Constants of the slot key stream cipher: segment layout, subfield layout,
 * retry limit, register offsets and register field positions.
 * Assumes it is included by its bare name from the package and the modules.
 */
// ==========================================================================
// Operation
// - Re-key: stop ciphering, then restart ciphering
// - New bearer keeps mode, key, initialization value
// - Both handover connections share frame segment pair
// - Second connection starts clear; release after encryption
// - External handover: new leg clear, start may wait
// - Failed key transfer: re-authenticate, fresh key
// - Two segments of 40 + j bits
// - Control tail: segment bits 0-39 onto tail
// - Unprotected: segment 40 onward onto B bits
// - Protected: 64 data XORed, 16 check unused
// - E-type multiplexed handled as protected multisubfield
// - Padding passes clear, its key bits dropped
// - Checks and X-field never encrypted
// - Codec format: only first j*r bits used
// - Segment pair totals 80 + 2j bits
// - Padding exists only when j equals 672
// - Mode switch covers all bearers, later ones too
// - Stop request repeated five even frames, else release
`ifndef SKC_DEFINES_SVH
`define SKC_DEFINES_SVH

// ==========================================================================
// segment and field layout
`define SKC_IDXW      10
`define SKC_TAIL_KS   10'h028
`define SKC_TAIL_OFS  10'h008
`define SKC_SUB_LEN   10'h050
`define SKC_SUB_DATA  10'h040
`define SKC_PAD_J     10'h2A0
`define SKC_RATIO_FB  4
`define SKC_NCONN     2

// ==========================================================================
// mode switching
`define SKC_RETRIES   3'h5

// ==========================================================================
// register port
`define SKC_AW        4
`define SKC_DW        32
`define SKC_REG_CMD   4'h0
`define SKC_REG_STAT  4'h4
`define SKC_REG_FRMS  4'h8

`define SKC_CMD_START   0
`define SKC_CMD_STOP    1
`define SKC_CMD_REKEY   2
`define SKC_CMD_CONN    3
`define SKC_CMD_HO      4
`define SKC_CMD_HO_EXT  5
`define SKC_CMD_REL_OLD 6
`define SKC_CMD_KEY_ERR 7

`define SKC_ST_ENC      0
`define SKC_ST_BUSY     2
`define SKC_ST_HO       3
`define SKC_ST_HO_EXT   4
`define SKC_ST_CONN     5
`define SKC_ST_REAUTH   6
`define SKC_ST_REFUSED  7
`define SKC_ST_OVERRUN  8

`endif

// File: shared/skc_pkg.sv
/*
 * Types of the slot key stream cipher: B-field formats, air commands,
 * controller states and the grouped stream and configuration carriers.
 * Assumes skc_defines.svh is reachable on the include path.
 */
`include "skc_defines.svh"

package skc_pkg;

   typedef enum logic [3:0] {
      FMT_UNPROT = 4'h1,
      FMT_MULTI  = 4'h2,
      FMT_ETYPE  = 4'h4,
      FMT_CODEC  = 4'h8
   } skc_fmt_e;

   typedef enum logic [2:0] {
      MT_NONE        = 3'h0,
      MT_START_REQ   = 3'h1,
      MT_START_GRANT = 3'h2,
      MT_STOP_REQ    = 3'h3,
      MT_STOP_GRANT  = 3'h4
   } skc_mt_e;

   typedef enum logic [4:0] {
      ST_IDLE        = 5'h01,
      ST_STOP_WAIT   = 5'h02,
      ST_STOP_GRANT  = 5'h04,
      ST_START_WAIT  = 5'h08,
      ST_START_GRANT = 5'h10
   } skc_state_e;

   typedef struct packed {
      skc_fmt_e                    fmt;
      logic [`SKC_IDXW-1:0]        bLen;
      logic [`SKC_RATIO_FB:0]      ratio;
      logic                        tailCt;
   } skc_cfg_s;

   typedef struct packed {
      logic valid;
      logic bit_;
   } skc_key_s;

   typedef struct packed {
      logic                    valid;
      logic [`SKC_NCONN-1:0]   lanes;
   } skc_lane_s;

   typedef struct packed {
      logic                    valid;
      logic [`SKC_NCONN-1:0]   lanes;
      logic                    inTail;
      logic                    segSel;
      logic [`SKC_IDXW-1:0]    idx;
   } skc_out_s;

   typedef struct packed {
      logic valid;
      logic conn;
   } skc_rel_s;

endpackage

// File: verilog/skc_bit_map.sv
/*
 * Maps one key stream segment index onto the tail or B-field bit it covers
 * and decides whether the key bit is applied or only dropped.
 * Assumes a legal configuration: protected lengths are whole subfields, or 672 with its padding.
 */
`include "skc_defines.svh"

module skc_bit_map
   import skc_pkg::*;
(
   input  wire logic [`SKC_IDXW-1:0] segIdx,
   input  wire skc_cfg_s             cfg,
   output logic                      keyUse,
   output logic                      inTail,
   output logic [`SKC_IDXW-1:0]      fieldIdx
);

   logic [`SKC_IDXW-1:0]               bIdx;
   logic [`SKC_IDXW-1:0]               subPos;
   logic [`SKC_IDXW-1:0]               padStart;
   logic [`SKC_IDXW-1:0]               payload;
   logic [`SKC_IDXW+`SKC_RATIO_FB:0]   prod;

   always_comb begin
      bIdx     = segIdx - `SKC_TAIL_KS;
      subPos   = bIdx % `SKC_SUB_LEN;
      padStart = (cfg.bLen / `SKC_SUB_LEN) * `SKC_SUB_LEN;
      prod     = cfg.bLen * cfg.ratio;
      payload  = prod[`SKC_RATIO_FB +: `SKC_IDXW];
      inTail   = segIdx < `SKC_TAIL_KS;
      fieldIdx = inTail ? segIdx + `SKC_TAIL_OFS : bIdx;
      keyUse   = 1'b0;
      if (inTail) begin
         keyUse = cfg.tailCt;
      end else begin
         unique case (cfg.fmt)
            FMT_UNPROT: keyUse = 1'b1;
            // multiplexed E-type shares the protected layout
            FMT_MULTI, FMT_ETYPE: begin
               keyUse = (subPos < `SKC_SUB_DATA)
                  && !((cfg.bLen == `SKC_PAD_J) && (bIdx >= padStart));
            end
            FMT_CODEC: keyUse = bIdx < payload;
            default:   keyUse = 1'b0;
         endcase
      end
   end

endmodule

// File: verilog/skc_mode_ctrl.sv
/*
 * Portable-side encryption mode switching: start, stop and re-key request
 * sequences with a bounded number of even-frame repeats.
 * Assumes frame ticks and received confirmations come from the same clock.
 */
`include "skc_defines.svh"

module skc_mode_ctrl
   import skc_pkg::*;
#(
   parameter logic [2:0] MAX_TRIES = `SKC_RETRIES
)(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic frameTick,
   input  wire logic frameEven,
   input  wire logic reqStart,
   input  wire logic reqStop,
   input  wire logic reqRekey,
   input  wire logic rxStartConf,
   input  wire logic rxStartReject,
   input  wire logic rxStopConf,
   output skc_mt_e   txCmd_q,
   output logic      grantOn_q,
   output logic      grantOff_q,
   output logic      dropLink_q,
   output logic      busy
);

   skc_state_e  state_q;
   logic [2:0]  tries_q;
   logic        rekey_q;
   logic        evenTick;
   logic        waitStop;
   logic        waitStart;

   assign evenTick  = frameTick & frameEven;
   assign busy      = state_q != ST_IDLE;
   assign waitStop  = (state_q == ST_STOP_WAIT) && !rxStopConf;
   assign waitStart = (state_q == ST_START_WAIT) && !rxStartConf && !rxStartReject;

   // ==========================================================================
   // sequence state
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         tries_q <= 3'h0;
         rekey_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               tries_q <= 3'h0;
               if (reqStart) begin
                  state_q <= ST_START_WAIT;
               end else if (reqStop || reqRekey) begin
                  state_q <= ST_STOP_WAIT;
                  rekey_q <= reqRekey;
               end
            end
            ST_STOP_WAIT: begin
               if (rxStopConf) begin
                  state_q <= ST_STOP_GRANT;
               end else if (evenTick) begin
                  if (tries_q == MAX_TRIES) begin
                     state_q <= ST_IDLE;
                  end else begin
                     tries_q <= tries_q + 3'h1;
                  end
               end
            end
            ST_STOP_GRANT: begin
               if (evenTick) begin
                  state_q <= rekey_q ? ST_START_WAIT : ST_IDLE;
                  tries_q <= 3'h0;
                  rekey_q <= 1'b0;
               end
            end
            ST_START_WAIT: begin
               if (rxStartConf) begin
                  state_q <= ST_START_GRANT;
               end else if (rxStartReject) begin
                  state_q <= ST_IDLE;
               end else if (evenTick) begin
                  if (tries_q == MAX_TRIES) begin
                     state_q <= ST_IDLE;
                  end else begin
                     tries_q <= tries_q + 3'h1;
                  end
               end
            end
            ST_START_GRANT: begin
               if (evenTick) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // air command and mode pulses, one command per even frame
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         txCmd_q    <= MT_NONE;
         grantOn_q  <= 1'b0;
         grantOff_q <= 1'b0;
         dropLink_q <= 1'b0;
      end else begin
         grantOn_q  <= 1'b0;
         grantOff_q <= 1'b0;
         dropLink_q <= 1'b0;
         if (frameTick) begin
            txCmd_q <= MT_NONE;
         end
         if (evenTick) begin
            if ((waitStop || waitStart) && tries_q == MAX_TRIES) begin
               dropLink_q <= 1'b1;
            end else if (waitStop) begin
               txCmd_q <= MT_STOP_REQ;
            end else if (waitStart) begin
               txCmd_q <= MT_START_REQ;
            end else if (state_q == ST_STOP_GRANT) begin
               txCmd_q    <= MT_STOP_GRANT;
               grantOff_q <= 1'b1;
            end else if (state_q == ST_START_GRANT) begin
               txCmd_q   <= MT_START_GRANT;
               grantOn_q <= 1'b1;
            end
         end
      end
   end

endmodule

// File: verilog/skc_keystream_cipher.sv
/*
 * Slot key stream cipher for half and long slots: XORs each frame's pair of
 * key stream segments onto the tail and B-field bits of every held
 * connection, and runs encryption mode, re-key and handover control.
 * Assumes the key stream generator and the MAC present key bit and field
 * bits in lockstep, segment index order, on the same clock.
 */
// The implementer's own choices: the placing of the registers and the strobed register port.
`include "skc_defines.svh"

module skc_keystream_cipher
   import skc_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic [`SKC_AW-1:0]     regAddr,
   input  wire logic [`SKC_DW-1:0]     regWrData,
   input  wire logic                   regWr,
   input  wire logic                   regRd,
   output logic [`SKC_DW-1:0]          regRdData,
   input  wire skc_cfg_s               cfg,
   input  wire logic                   frameStart,
   input  wire logic                   frameEven,
   input  wire skc_key_s               keyIn,
   input  wire skc_lane_s              dataIn,
   output skc_out_s                    dataOut,
   output logic                        frameDone,
   input  wire logic                   rxStartConf,
   input  wire logic                   rxStartReject,
   input  wire logic                   rxStopConf,
   output skc_mt_e                     txCmd,
   output skc_rel_s                    connRelease
);

   // ==========================================================================
   // declarations
   logic [`SKC_IDXW-1:0]   segIdx_q;
   logic                   segSel_q;
   logic                   frameEnd_q;
   logic [`SKC_IDXW-1:0]   lastIdx;
   logic                   step;
   logic                   keyUse;
   logic                   inTail;
   logic [`SKC_IDXW-1:0]   fieldIdx;
   logic [`SKC_NCONN-1:0]  encOn_q;
   logic                   ctlConn_q;
   logic                   hoActive_q;
   logic                   hoExt_q;
   logic                   oldConn_q;
   logic                   reauth_q;
   logic                   refused_q;
   logic                   overrun_q;
   logic [`SKC_DW-1:0]     frames_q;
   logic                   cmdWr;
   logic                   statWr;
   logic                   wantStart;
   logic                   wantStop;
   logic                   wantRekey;
   logic                   newConn;
   logic                   startBlocked;
   logic                   relOk;
   logic                   reqStart;
   logic                   reqStop;
   logic                   reqRekey;
   logic                   refuse;
   logic                   grantOn;
   logic                   grantOff;
   logic                   dropLink;
   logic                   busy;
   skc_mt_e                ctlCmd;

   function automatic logic cmdBit(input logic [`SKC_DW-1:0] w, input int unsigned pos);
      cmdBit = w[pos];
   endfunction

   // ==========================================================================
   // register port decode
   assign cmdWr     = regWr && (regAddr == `SKC_REG_CMD);
   assign statWr    = regWr && (regAddr == `SKC_REG_STAT);
   assign wantStart = cmdWr && cmdBit(regWrData, `SKC_CMD_START);
   assign wantStop  = cmdWr && cmdBit(regWrData, `SKC_CMD_STOP);
   assign wantRekey = cmdWr && cmdBit(regWrData, `SKC_CMD_REKEY);
   assign newConn   = cmdBit(regWrData, `SKC_CMD_CONN);

   // external handover: the new leg may not start while the old one still ciphers
   assign startBlocked = hoActive_q && hoExt_q && (newConn != oldConn_q)
                         && encOn_q[oldConn_q];
   // the first connection goes only once the second one is encrypted
   assign relOk    = hoActive_q && encOn_q[!oldConn_q];
   assign reqStart = wantStart && !busy && !startBlocked;
   assign reqStop  = wantStop && !busy;
   assign reqRekey = wantRekey && !busy && encOn_q[newConn];
   assign refuse   = (wantStart && (busy || startBlocked))
                     || ((wantStop || wantRekey) && busy)
                     || (wantRekey && !encOn_q[newConn])
                     || (cmdWr && cmdBit(regWrData, `SKC_CMD_REL_OLD) && !relOk);

   // ==========================================================================
   // mode switching sequences
   skc_mode_ctrl #(
      .MAX_TRIES     (`SKC_RETRIES)
   ) u_mode_ctrl (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .frameTick     (frameStart),
      .frameEven     (frameEven),
      .reqStart      (reqStart),
      .reqStop       (reqStop),
      .reqRekey      (reqRekey),
      .rxStartConf   (rxStartConf),
      .rxStartReject (rxStartReject),
      .rxStopConf    (rxStopConf),
      .txCmd_q       (ctlCmd),
      .grantOn_q     (grantOn),
      .grantOff_q    (grantOff),
      .dropLink_q    (dropLink),
      .busy          (busy)
   );

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         txCmd <= MT_NONE;
      end else begin
         txCmd <= ctlCmd;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctlConn_q <= 1'b0;
      end else if (reqStart || reqStop || reqRekey) begin
         ctlConn_q <= newConn;
      end
   end

   // ==========================================================================
   // per-connection encryption mode; every bearer of a connection follows it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         encOn_q <= '0;
      end else begin
         if (grantOn) begin
            encOn_q[ctlConn_q] <= 1'b1;
         end
         if (grantOff || dropLink) begin
            encOn_q[ctlConn_q] <= 1'b0;
         end
         if (cmdWr && cmdBit(regWrData, `SKC_CMD_HO)) begin
            encOn_q[!newConn] <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // connection and external handover bookkeeping
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hoActive_q <= 1'b0;
         hoExt_q    <= 1'b0;
         oldConn_q  <= 1'b0;
      end else if (cmdWr && cmdBit(regWrData, `SKC_CMD_HO)) begin
         hoActive_q <= 1'b1;
         hoExt_q    <= cmdBit(regWrData, `SKC_CMD_HO_EXT);
         oldConn_q  <= newConn;
      end else if (cmdWr && cmdBit(regWrData, `SKC_CMD_REL_OLD) && relOk) begin
         hoActive_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         connRelease <= '0;
      end else if (dropLink) begin
         connRelease <= '{valid: 1'b1, conn: ctlConn_q};
      end else if (cmdWr && cmdBit(regWrData, `SKC_CMD_REL_OLD) && relOk) begin
         connRelease <= '{valid: 1'b1, conn: oldConn_q};
      end else begin
         connRelease <= '0;
      end
   end

   // a failed key transfer leaves the new leg unable to resume: re-authenticate
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reauth_q <= 1'b0;
      end else if (cmdWr && cmdBit(regWrData, `SKC_CMD_KEY_ERR)) begin
         reauth_q <= 1'b1;
      end else if (statWr && cmdBit(regWrData, `SKC_ST_REAUTH)) begin
         reauth_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         refused_q <= 1'b0;
      end else if (refuse) begin
         refused_q <= 1'b1;
      end else if (statWr && cmdBit(regWrData, `SKC_ST_REFUSED)) begin
         refused_q <= 1'b0;
      end
   end

   // ==========================================================================
   // segment position: two segments of 40 + j bits per frame
   assign lastIdx = `SKC_TAIL_KS + cfg.bLen - 10'h001;
   assign step    = keyIn.valid && dataIn.valid && !frameEnd_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         segIdx_q   <= '0;
         segSel_q   <= 1'b0;
         frameEnd_q <= 1'b0;
      end else if (frameStart) begin
         segIdx_q   <= '0;
         segSel_q   <= 1'b0;
         frameEnd_q <= 1'b0;
      end else if (step) begin
         if (segIdx_q == lastIdx) begin
            segIdx_q <= '0;
            segSel_q <= 1'b1;
            if (segSel_q) begin
               frameEnd_q <= 1'b1;
            end
         end else begin
            segIdx_q <= segIdx_q + 10'h001;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         frameDone <= 1'b0;
      end else begin
         frameDone <= step && segSel_q && (segIdx_q == lastIdx);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         overrun_q <= 1'b0;
      end else if (keyIn.valid && dataIn.valid && frameEnd_q && !frameStart) begin
         overrun_q <= 1'b1;
      end else if (statWr && cmdBit(regWrData, `SKC_ST_OVERRUN)) begin
         overrun_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         frames_q <= '0;
      end else if (step && segSel_q && (segIdx_q == lastIdx)) begin
         frames_q <= frames_q + 32'h0000_0001;
      end
   end

   // ==========================================================================
   // bit mapping and XOR; the same key bit feeds every held connection
   skc_bit_map u_bit_map (
      .segIdx   (segIdx_q),
      .cfg      (cfg),
      .keyUse   (keyUse),
      .inTail   (inTail),
      .fieldIdx (fieldIdx)
   );

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dataOut.valid  <= 1'b0;
         dataOut.inTail <= 1'b0;
         dataOut.segSel <= 1'b0;
         dataOut.idx    <= '0;
      end else begin
         dataOut.valid  <= step;
         dataOut.inTail <= inTail;
         dataOut.segSel <= segSel_q;
         dataOut.idx    <= fieldIdx;
      end
   end

   for (genvar c = 0; c < `SKC_NCONN; c++) begin : g_lane
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            dataOut.lanes[c] <= 1'b0;
         end else begin
            // bearers of a connection share its key and value
            dataOut.lanes[c] <= dataIn.lanes[c] ^ (keyIn.bit_ & keyUse & encOn_q[c]);
         end
      end
   end

   // ==========================================================================
   // register read, data in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         regRdData <= '0;
      end else begin
         regRdData <= '0;
         if (regRd) begin
            unique case (regAddr)
               `SKC_REG_CMD: regRdData[`SKC_CMD_CONN] <= ctlConn_q;
               `SKC_REG_STAT: begin
                  regRdData[`SKC_ST_ENC +: `SKC_NCONN] <= encOn_q;
                  regRdData[`SKC_ST_BUSY]    <= busy;
                  regRdData[`SKC_ST_HO]      <= hoActive_q;
                  regRdData[`SKC_ST_HO_EXT]  <= hoExt_q;
                  regRdData[`SKC_ST_CONN]    <= ctlConn_q;
                  regRdData[`SKC_ST_REAUTH]  <= reauth_q;
                  regRdData[`SKC_ST_REFUSED] <= refused_q;
                  regRdData[`SKC_ST_OVERRUN] <= overrun_q;
               end
               `SKC_REG_FRMS: regRdData <= frames_q;
               default: regRdData <= '0;
            endcase
         end
      end
   end

endmodule

// File: verification/skc_keystream_cipher_sva.sv
/* Checker for skc_keystream_cipher, bound to its ports.
   Assumes a single clock domain with synchronous active-low reset. */
`include "skc_defines.svh"
module skc_keystream_cipher_sva
   import skc_pkg::*;
(
   input wire logic                ref_clk,
   input wire logic                rst_n,
   input wire logic                regRd,
   input wire logic [`SKC_DW-1:0]  regRdData,
   input wire skc_cfg_s            cfg,
   input wire logic                frameStart,
   input wire skc_key_s            keyIn,
   input wire skc_lane_s           dataIn,
   input wire skc_out_s            dataOut,
   input wire logic                frameDone,
   input wire skc_mt_e             txCmd,
   input wire skc_rel_s            connRelease
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [`SKC_IDXW-1:0] bIdx;
   assign bIdx = dataOut.idx;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_rd; !$past(regRd) |-> regRdData == '0; endproperty
   a_rd: assert property (p_rd) else $error("read data outside its cycle");
   property p_vld; dataOut.valid |-> $past(keyIn.valid && dataIn.valid); endproperty
   a_vld: assert property (p_vld) else $error("output without input bit");
   property p_tail; dataOut.valid && dataOut.inTail && !$past(cfg.tailCt)
      |-> dataOut.lanes == $past(dataIn.lanes); endproperty
   a_tail: assert property (p_tail) else $error("non-control tail altered");
   property p_crc; dataOut.valid && !dataOut.inTail && $past(cfg.fmt) inside {FMT_MULTI, FMT_ETYPE}
      && bIdx % 80 >= 64 |-> dataOut.lanes == $past(dataIn.lanes); endproperty
   a_crc: assert property (p_crc) else $error("check field altered");
   property p_pad; dataOut.valid && !dataOut.inTail && $past(cfg.fmt) inside {FMT_MULTI, FMT_ETYPE}
      && $past(cfg.bLen) == `SKC_PAD_J && bIdx >= 640 |-> dataOut.lanes == $past(dataIn.lanes);
   endproperty
   a_pad: assert property (p_pad) else $error("padding altered");
   property p_cdc; dataOut.valid && !dataOut.inTail && $past(cfg.fmt) == FMT_CODEC
      && bIdx >= ((15'($past(cfg.bLen)) * $past(cfg.ratio)) >> 4)
      |-> dataOut.lanes == $past(dataIn.lanes); endproperty
   a_cdc: assert property (p_cdc) else $error("codec tail bits altered");
   property p_done; frameDone |-> dataOut.valid && dataOut.segSel; endproperty
   a_done: assert property (p_done) else $error("frame end misplaced");
   property p_cmd; $changed(txCmd) |-> $past(frameStart, 2); endproperty
   a_cmd: assert property (p_cmd) else $error("air command off frame");
   property p_rel; connRelease.valid |=> !connRelease.valid; endproperty
   a_rel: assert property (p_rel) else $error("release pulse too long");
endmodule
bind skc_keystream_cipher skc_keystream_cipher_sva sva_u(.ref_clk, .rst_n, .regRd, .regRdData,
   .cfg, .frameStart, .keyIn, .dataIn, .dataOut, .frameDone, .txCmd, .connRelease);

// File: verification/skc_peer_model.sv
/* Fixed side peer: confirms start and stop requests in the odd frame after.
   Assumes txCmd still shows the request when the odd frame starts. */
module skc_peer_model
   import skc_pkg::*;
(
   input  wire logic    ref_clk,
   input  wire logic    rst_n,
   input  wire logic    frameStart,
   input  wire logic    frameEven,
   input  wire logic    mute,
   input  wire skc_mt_e txCmd,
   output logic         rxStartConf,
   output logic         rxStartReject,
   output logic         rxStopConf
);
   timeunit 1ns;
   timeprecision 1ps;
   logic odd;
   assign odd = frameStart && !frameEven && !mute;
   assign rxStartReject = 1'b0;
   always_ff @(posedge ref_clk) begin
      rxStartConf <= rst_n && odd && txCmd == MT_START_REQ;
      rxStopConf  <= rst_n && odd && txCmd == MT_STOP_REQ;
   end
endmodule

// File: verification/tb_skc_keystream_cipher.sv
/* Testbench for skc_keystream_cipher with peer model.
   Assumes the checker is bound from its own file. */
module tb_skc_keystream_cipher
   import skc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_n = 0, regWr = 0, regRd = 0, frameStart = 0, frameEven = 0;
   logic mute = 0, relSeen = 0, fe = 1, frameDone, rxStartConf, rxStartReject, rxStopConf;
   logic [3:0] regAddr = '0;
   logic [31:0] regWrData = '0, regRdData;
   skc_cfg_s cfg = '0;
   skc_key_s keyIn = '0;
   skc_lane_s dataIn = '0;
   skc_out_s dataOut;
   skc_mt_e txCmd;
   skc_rel_s connRelease;
   int n_fail = 0, cmp_count = 0;
   skc_fmt_e fa[4] = '{FMT_UNPROT, FMT_MULTI, FMT_ETYPE, FMT_CODEC};
   int ja[4] = '{80, 160, 672, 80};
   skc_keystream_cipher dut_u(.ref_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
      .cfg, .frameStart, .frameEven, .keyIn, .dataIn, .dataOut, .frameDone, .rxStartConf,
      .rxStartReject, .rxStopConf, .txCmd, .connRelease);
   skc_peer_model peer_u(.ref_clk, .rst_n, .frameStart, .frameEven, .mute, .txCmd,
      .rxStartConf, .rxStartReject, .rxStopConf);
   initial forever #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (connRelease.valid === 1'b1) relSeen <= 1'b1;
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a; regWrData <= d; regWr <= 1; @(posedge ref_clk);
      regWr <= 0; @(posedge ref_clk);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      regAddr <= a; regRd <= 1; @(posedge ref_clk);
      regRd <= 0; #1 chk(regRdData, e); @(posedge ref_clk);
   endtask
   function logic keyUsed(input int k);
      int b;
      b = k - 40;
      if (k < 40) return cfg.tailCt;
      case (cfg.fmt)
         FMT_UNPROT: return 1'b1;
         FMT_CODEC: return b < ((cfg.bLen * cfg.ratio) >> 4);
         default: return (b % 80 < 64) && !(cfg.bLen == 672 && b >= 640);
      endcase
   endfunction
   task frm(input int nb, input logic en);
      int j;
      j = cfg.bLen;
      frameStart <= 1; frameEven <= fe; fe = !fe; @(posedge ref_clk);
      frameStart <= 0;
      for (int i = 0; i < nb; i++) begin
         keyIn <= 2'b11; dataIn <= 3'b111; @(posedge ref_clk);
         keyIn <= '0; dataIn <= '0;
         #1 if (i < 2 * (40 + j)) chk({dataOut.valid, dataOut.lanes},
            {1'b1, 1'b1, !(keyUsed(i % (40 + j)) & en)});
         @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
   endtask
   task results;
      $display("checks=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #2500us n_fail++;
      results;
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1; @(posedge ref_clk);
      rd(4'h4, 32'h0); rd(4'hC, 32'h0);
      wr(4'h0, 32'h4); rd(4'h4, 32'h80);
      wr(4'h4, 32'h80); rd(4'h4, 32'h0);
      $display("test registers done");
      cfg <= '{FMT_MULTI, 10'd80, 5'h10, 1'b1}; @(posedge ref_clk);
      frm(240, 0);
      wr(4'h0, 32'h1); repeat (6) frm(0, 0); rd(4'h4, 32'h1);
      $display("test start done");
      for (int i = 0; i < 4; i++) begin
         cfg <= '{fa[i], 10'(ja[i]), 5'h08, i[0]}; @(posedge ref_clk);
         frm(2 * (40 + ja[i]) + (i == 3), 1);
      end
      rd(4'h4, 32'h101); wr(4'h4, 32'h100); rd(4'h4, 32'h1);
      $display("test formats done");
      wr(4'h0, 32'h4); repeat (12) frm(0, 0); rd(4'h4, 32'h1);
      $display("test rekey done");
      mute <= 1; wr(4'h0, 32'h2); repeat (14) frm(0, 0); chk(relSeen, 1);
      $display("test stop timeout done");
      results;
   end
endmodule
